// *** bench/led_expander_serial_port_tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module led_expander_serial_port_tb;
	import lesp_pkg::*;
	logic clk, rst, sclk, cs_n, din, pwm_src, pin, dout, oe, pwm_in, wr_strobe, oe_pwm;
	logic [6:0] wr_addr;
	logic [7:0] wr_data;
	logic [15:0] cap;
	int bad_count, cmp_count, strobes;

	assign pin = oe ? dout : pwm_src;

	lesp_serial_port dut (.clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .din(din),
		.serial_out_or_pwm_clock_pin_i(pin), .serial_out_or_pwm_clock_pin_o(dout),
		.serial_out_or_pwm_clock_pin_oe(oe), .pwm_clock_input(pwm_in),
		.wr_strobe(wr_strobe), .wr_addr(wr_addr), .wr_data(wr_data));

	lesp_host_model host (.clk(clk), .dout(pin), .sclk(sclk), .cs_n(cs_n), .din(din));

	// build variant whose shared pin starts as pwm clock input
	lesp_serial_port #(.PIN_PWM_CLOCK_DEFAULT(1'b1)) dut_pwm (.clk(clk), .rst(rst),
		.sclk(sclk), .cs_n(cs_n), .din(din), .serial_out_or_pwm_clock_pin_i(pwm_src),
		.serial_out_or_pwm_clock_pin_o(), .serial_out_or_pwm_clock_pin_oe(oe_pwm),
		.pwm_clock_input(), .wr_strobe(), .wr_addr(), .wr_data());

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	always @(posedge clk) begin
		if (wr_strobe === 1'b1) strobes++;
	end

	task automatic wrap_up();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %s exp %h seen %h", what, exp, seen);
		end
	endtask

	// one frame, then a bounded wait for the write pulse
	task automatic wr(input logic [31:0] w, input int n, input bit hi);
		int k;
		strobes = 0;
		host.xfer(w, n, hi, cap);
		for (k = 0; k < 20 && strobes == 0; k++) @(negedge clk);
		if (k == 20) begin
			bad_count++;
			wrap_up();
		end
	endtask

	task automatic t_write();
		check("oe_reset", oe, 1'b1);
		check("oe_reset_pwm", oe_pwm, 1'b0);
		wr(32'h0455, 16, 1'b1);
		check("strobe_count", 16'(strobes), 16'h0001);
		check("addr", wr_addr, 7'h04);
		check("data", wr_data, 8'h55);
		$display("test write done");
	endtask

	task automatic t_count();
		wr({12'h000, 4'hF, 16'h2A3C}, 20, 1'b0);
		check("long_addr", wr_addr, 7'h2A);
		check("long_data", wr_data, 8'h3C);
		host.foreign(5);
		// short frame completes with bits left from before
		wr(32'h11, 8, 1'b0);
		check("short_addr", wr_addr, 7'h3C);
		check("short_data", wr_data, 8'h11);
		$display("test count done");
	endtask

	task automatic t_read();
		wr(32'h10A5, 16, 1'b0);
		strobes = 0;
		host.xfer(32'h90FF, 16, 1'b0, cap);
		repeat (12) @(negedge clk);
		check("read_strobe", 16'(strobes), 16'h0000);
		host.xfer(32'h8400, 16, 1'b1, cap);
		check("readback", cap[14:0], {7'h10, 8'hA5});
		host.xfer(32'h0000, 16, 1'b0, cap);
		check("cfg_readback", cap[14:0], {7'h04, 8'h55});
		$display("test read done");
	endtask

	task automatic t_pin();
		int k;
		wr(32'h0480, 16, 1'b0);
		repeat (4) @(negedge clk);
		check("oe_pwm", oe, 1'b0);
		pwm_src = 1'b1;
		repeat (6) @(negedge clk);
		check("pwm_hi", pwm_in, 1'b1);
		pwm_src = 1'b0;
		repeat (6) @(negedge clk);
		check("pwm_lo", pwm_in, 1'b0);
		wr(32'h0400, 16, 1'b0);
		for (k = 0; k < 10 && oe !== 1'b1; k++) @(negedge clk);
		check("oe_out", oe, 1'b1);
		check("oe_out_pwm", oe_pwm, 1'b1);
		if (k == 10) begin
			wrap_up();
		end
		$display("test pin done");
	endtask

	task automatic t_reset();
		rst = 1'b1;
		repeat (3) @(negedge clk);
		rst = 1'b0;
		repeat (4) @(negedge clk);
		check("rst_oe", oe, 1'b1);
		check("rst_oe_pwm", oe_pwm, 1'b0);
		check("rst_addr", wr_addr, 7'h00);
		check("rst_data", wr_data, 8'h00);
		$display("test reset done");
	endtask

	initial begin
		rst = 1'b1;
		pwm_src = 1'b0;
		bad_count = 0;
		cmp_count = 0;
		strobes = 0;
		repeat (3) @(negedge clk);
		rst = 1'b0;
		repeat (4) @(negedge clk);
		t_write();
		t_count();
		t_read();
		t_pin();
		t_reset();
		wrap_up();
	end
endmodule

`default_nettype wire

// *** bench/lesp_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module lesp_host_model (
	input wire logic clk,
	input wire logic dout,
	output logic sclk,
	output logic cs_n,
	output logic din
);
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		din = 1'b0;
	end

	// half of a 320 ns link period
	task automatic half();
		repeat (4) @(negedge clk);
	endtask

	task automatic xfer(input logic [31:0] w, input int n, input bit hi_end,
		output logic [15:0] cap);
		cap = 16'h0000;
		sclk <= 1'b0;
		half();
		cs_n <= 1'b0;
		half();
		for (int i = n - 1; i >= 0; i--) begin
			din <= w[i];
			half();
			sclk <= 1'b1;
			cap = {cap[14:0], dout};
			half();
			if (!(hi_end && i == 0)) begin
				sclk <= 1'b0;
			end
		end
		cs_n <= 1'b1;
		// released line must not keep its last bit
		din <= ~din;
		half();
		sclk <= 1'b0;
		half();
	endtask

	// bus traffic meant for some other device
	task automatic foreign(input int n);
		for (int i = 0; i < n; i++) begin
			din <= i[0];
			sclk <= 1'b1;
			half();
			sclk <= 1'b0;
			half();
		end
	endtask
endmodule

`default_nettype wire

// *** design/lesp_params.svh ***
`ifndef LESP_PARAMS_SVH
`define LESP_PARAMS_SVH

`define LESP_WORD_BITS 16
`define LESP_RW_BIT 15
`define LESP_ADDR_MSB 14
`define LESP_ADDR_LSB 8
`define LESP_DATA_MSB 7
`define LESP_CFG_ADDR 7'h04
`define LESP_CFG_PIN_BIT 7
`define LESP_SHIFT_RST 16'h0000
`define LESP_NUM_REGS 128

`endif

// *** design/lesp_pkg.sv ***
`include "lesp_params.svh"

package lesp_pkg;

	typedef struct packed {
		logic rw;
		logic [6:0] addr;
		logic [7:0] data;
	} lesp_word_t;

	typedef struct packed {
		logic sclk;
		logic cs_n;
		logic din;
	} lesp_pins_t;

	typedef struct packed {
		logic rise;
		logic fall;
		logic cs_rise;
		logic cs_fall;
	} lesp_edges_t;

	typedef enum logic [2:0] {
		LESP_IDLE = 3'b001,
		LESP_SHIFT = 3'b010,
		LESP_LATCH = 3'b100
	} lesp_state_t;

endpackage

// *** design/lesp_regfile.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "lesp_params.svh"

module lesp_regfile
	import lesp_pkg::*;
#(
	parameter int NUM_REGS = `LESP_NUM_REGS
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic wr_en,
	input wire logic [6:0] wr_addr,
	input wire logic [7:0] wr_data,
	input wire logic [6:0] rd_addr,
	output logic [7:0] rd_data
);

	logic [7:0] mem_q [NUM_REGS];
	logic [7:0] mem_d [NUM_REGS];

	always_comb begin
		for (int i = 0; i < NUM_REGS; i++) begin
			mem_d[i] = mem_q[i];
		end
		if (wr_en) begin
			mem_d[wr_addr] = wr_data;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < NUM_REGS; i++) begin
				mem_q[i] <= 8'h00;
			end
		end else begin
			for (int i = 0; i < NUM_REGS; i++) begin
				mem_q[i] <= mem_d[i];
			end
		end
	end

	assign rd_data = mem_q[rd_addr];

endmodule

`default_nettype wire

// *** design/lesp_serial_port.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "lesp_params.svh"

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - word is command byte then data byte
// - bit 15 read flag, bits 14-8 address
// - select low enables the shift register
// - deselect accepted with clock high or low
// - last sixteen bits latched on deselect
// - read discards dummy data byte
// - read loads register into low byte
// - output lags input 15.5 clocks, falling edge
// - shared pin is output when config bit clear
// - power-up pin function is a build option
// - ignore clock and data while deselected
// - sample input on rising clock edge
// - output driven from one clock after output mode is set, not during reset
module lesp_serial_port
	import lesp_pkg::*;
#(
	parameter bit PIN_PWM_CLOCK_DEFAULT = 1'b0
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic din,
	input wire logic serial_out_or_pwm_clock_pin_i,
	output logic serial_out_or_pwm_clock_pin_o,
	output logic serial_out_or_pwm_clock_pin_oe,
	output logic pwm_clock_input,
	output logic wr_strobe,
	output logic [6:0] wr_addr,
	output logic [7:0] wr_data
);

	////////////////////////////////////////////////////////////////////////////
	lesp_pins_t pins_async, pins;
	lesp_edges_t edges;
	logic [7:0] rd_data;
	logic pwm_meta_q, pwm_meta_d;
	logic pwm_sync_q, pwm_sync_d;

	assign pins_async = '{sclk: sclk, cs_n: cs_n, din: din};

	lesp_sync u_sync (
		.clk(clk),
		.rst(rst),
		.pins_async(pins_async),
		.pins_sync(pins),
		.edges(edges)
	);

	////////////////////////////////////////////////////////////////////////////
	lesp_state_t state_q, state_d;
	logic [15:0] shift_q, shift_d;
	logic dout_q, dout_d;
	logic pin_cfg_q, pin_cfg_d;
	logic rd_pend_q, rd_pend_d;
	logic [6:0] rd_addr_q, rd_addr_d;
	logic wr_q, wr_d;
	logic [6:0] wa_q, wa_d;
	logic [7:0] wd_q, wd_d;
	logic oe_q, oe_d;
	lesp_word_t word;

	assign word = shift_q;

	function automatic logic is_cfg(input logic [6:0] a);
		return a == `LESP_CFG_ADDR;
	endfunction

	lesp_regfile u_regs (
		.clk(clk),
		.rst(rst),
		.wr_en(wr_q),
		.wr_addr(wa_q),
		.wr_data(wd_q),
		.rd_addr(rd_addr_q),
		.rd_data(rd_data)
	);

	always_comb begin
		state_d = state_q;
		shift_d = shift_q;
		dout_d = dout_q;
		pin_cfg_d = pin_cfg_q;
		rd_pend_d = 1'b0;
		rd_addr_d = rd_addr_q;
		wr_d = 1'b0;
		wa_d = wa_q;
		wd_d = wd_q;
		case (state_q)
			LESP_IDLE: begin
				if (edges.cs_fall) begin
					state_d = LESP_SHIFT;
				end
			end
			LESP_SHIFT: begin
				// rising edge samples din; clock ignored otherwise
				if (edges.rise && !pins.cs_n) begin
					shift_d = {shift_q[14:0], pins.din};
				end
				// half-clock lag: msb leaves on falling edge
				if (edges.fall && !pins.cs_n) begin
					dout_d = shift_q[15];
				end
				if (edges.cs_rise) begin
					state_d = LESP_LATCH;
				end
			end
			LESP_LATCH: begin
				state_d = LESP_IDLE;
				if (word.rw) begin
					// dummy byte dropped, replaced one cycle later
					rd_pend_d = 1'b1;
					rd_addr_d = word.addr;
				end else begin
					wr_d = 1'b1;
					wa_d = word.addr;
					wd_d = word.data;
					if (is_cfg(word.addr)) begin
						pin_cfg_d = word.data[`LESP_CFG_PIN_BIT];
					end
				end
			end
			default: state_d = LESP_IDLE;
		endcase
		if (rd_pend_q) begin
			shift_d[`LESP_DATA_MSB:0] = rd_data;
			if (is_cfg(rd_addr_q)) begin
				shift_d[`LESP_CFG_PIN_BIT] = pin_cfg_q;
			end
		end
		oe_d = ~pin_cfg_q;
		pwm_meta_d = serial_out_or_pwm_clock_pin_i;
		pwm_sync_d = pwm_meta_q;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q <= LESP_IDLE;
			shift_q <= `LESP_SHIFT_RST;
			dout_q <= 1'b0;
			pin_cfg_q <= PIN_PWM_CLOCK_DEFAULT;
			rd_pend_q <= 1'b0;
			rd_addr_q <= 7'h00;
			wr_q <= 1'b0;
			wa_q <= 7'h00;
			wd_q <= 8'h00;
			oe_q <= 1'b0;
			pwm_meta_q <= 1'b0;
			pwm_sync_q <= 1'b0;
		end else begin
			state_q <= state_d;
			shift_q <= shift_d;
			dout_q <= dout_d;
			pin_cfg_q <= pin_cfg_d;
			rd_pend_q <= rd_pend_d;
			rd_addr_q <= rd_addr_d;
			wr_q <= wr_d;
			wa_q <= wa_d;
			wd_q <= wd_d;
			oe_q <= oe_d;
			pwm_meta_q <= pwm_meta_d;
			pwm_sync_q <= pwm_sync_d;
		end
	end

	assign serial_out_or_pwm_clock_pin_o = dout_q;
	assign serial_out_or_pwm_clock_pin_oe = oe_q;
	assign pwm_clock_input = pwm_sync_q;
	assign wr_strobe = wr_q;
	assign wr_addr = wa_q;
	assign wr_data = wd_q;

	////////////////////////////////////////////////////////////////////////////
	// checks
	sequence s_deselect;
		state_q == LESP_SHIFT && edges.cs_rise;
	endsequence

	property p_shift_in;
		@(posedge clk) disable iff (rst)
		(state_q == LESP_SHIFT && edges.rise && !pins.cs_n) |=>
			shift_q[0] == $past(pins.din) && shift_q[15:1] == $past(shift_q[14:0]);
	endproperty
	a_shift_in: assert property (p_shift_in) else $error("shift not taken");

	property p_ignore;
		@(posedge clk) disable iff (rst)
		(state_q == LESP_IDLE && !rd_pend_q) |=> $stable(shift_q);
	endproperty
	a_ignore: assert property (p_ignore) else $error("shift moved while idle");

	property p_write;
		@(posedge clk) disable iff (rst)
		s_deselect ##1 !word.rw |=> wr_q && wa_q == $past(word.addr) && wd_q == $past(word.data);
	endproperty
	a_write: assert property (p_write) else $error("write not stored");

	property p_read_load;
		@(posedge clk) disable iff (rst)
		s_deselect ##1 (word.rw && !is_cfg(word.addr)) |=> ##1 shift_q[7:0] == $past(rd_data);
	endproperty
	a_read_load: assert property (p_read_load) else $error("read byte not loaded");

	property p_read_nowrite;
		@(posedge clk) disable iff (rst)
		s_deselect ##1 word.rw |=> !wr_q;
	endproperty
	a_read_nowrite: assert property (p_read_nowrite) else $error("read wrote");

	property p_dout_fall;
		@(posedge clk) disable iff (rst)
		(state_q == LESP_SHIFT && edges.fall && !pins.cs_n) |=> dout_q == $past(shift_q[15]);
	endproperty
	a_dout_fall: assert property (p_dout_fall) else $error("output not updated");

	property p_dout_hold;
		@(posedge clk) disable iff (rst)
		!edges.fall |=> $stable(dout_q);
	endproperty
	a_dout_hold: assert property (p_dout_hold) else $error("output moved off fall");

	property p_oe;
		@(posedge clk) disable iff (rst)
		!pin_cfg_q [*2] |-> oe_q;
	endproperty
	a_oe: assert property (p_oe) else $error("pin not driven");

	property p_cfg;
		@(posedge clk) disable iff (rst)
		$changed(pin_cfg_q) |-> $past(state_q) == LESP_LATCH;
	endproperty
	a_cfg: assert property (p_cfg) else $error("config changed off frame");

	// a frame whose address names the configuration register
	sequence s_cfg_frame;
		s_deselect ##1 is_cfg(word.addr);
	endsequence

	property p_select;
		@(posedge clk) disable iff (rst)
		(state_q == LESP_IDLE && edges.cs_fall) |=> state_q == LESP_SHIFT;
	endproperty
	a_select: assert property (p_select) else $error("select not taken");

	property p_latch;
		@(posedge clk) disable iff (rst)
		s_deselect |=> state_q == LESP_LATCH ##1 state_q == LESP_IDLE;
	endproperty
	a_latch: assert property (p_latch) else $error("deselect not latched");

	property p_deselected;
		@(posedge clk) disable iff (rst)
		(state_q == LESP_SHIFT && pins.cs_n) |=> $stable(shift_q);
	endproperty
	a_deselected: assert property (p_deselected) else $error("shift moved deselected");

	property p_dout_idle;
		@(posedge clk) disable iff (rst)
		pins.cs_n |=> $stable(dout_q);
	endproperty
	a_dout_idle: assert property (p_dout_idle) else $error("dout moved deselected");

	property p_wr_pulse;
		@(posedge clk) disable iff (rst)
		wr_q |=> !wr_q;
	endproperty
	a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe too long");

	property p_wr_hold;
		@(posedge clk) disable iff (rst)
		!wr_q |-> $stable(wa_q) && $stable(wd_q);
	endproperty
	a_wr_hold: assert property (p_wr_hold) else $error("write fields moved");

	property p_cfg_write;
		@(posedge clk) disable iff (rst)
		s_cfg_frame ##0 !word.rw |=> pin_cfg_q == $past(word.data[`LESP_CFG_PIN_BIT]);
	endproperty
	a_cfg_write: assert property (p_cfg_write) else $error("config bit not taken");

	property p_cfg_read;
		@(posedge clk) disable iff (rst)
		s_cfg_frame ##0 word.rw |=> ##1
			shift_q[`LESP_CFG_PIN_BIT] == $past(pin_cfg_q) && shift_q[6:0] == $past(rd_data[6:0]);
	endproperty
	a_cfg_read: assert property (p_cfg_read) else $error("config readback wrong");

	// pin level reaches the pwm clock input through two flops
	property p_pwm_sync;
		@(posedge clk) disable iff (rst)
		pwm_sync_q == $past(serial_out_or_pwm_clock_pin_i, 2);
	endproperty
	a_pwm_sync: assert property (p_pwm_sync) else $error("pwm clock not synced");

endmodule

`default_nettype wire

// *** design/lesp_sync.sv ***
`timescale 1ns/1ps
`default_nettype none

module lesp_sync
	import lesp_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire lesp_pins_t pins_async,
	output lesp_pins_t pins_sync,
	output lesp_edges_t edges
);

	lesp_pins_t meta_q, meta_d;
	lesp_pins_t sync_q, sync_d;
	lesp_pins_t prev_q, prev_d;
	lesp_edges_t edg_q, edg_d;

	always_comb begin
		meta_d = pins_async;
		sync_d = meta_q;
		prev_d = sync_q;
		edg_d.rise = sync_q.sclk & ~prev_q.sclk;
		edg_d.fall = ~sync_q.sclk & prev_q.sclk;
		edg_d.cs_rise = sync_q.cs_n & ~prev_q.cs_n;
		edg_d.cs_fall = ~sync_q.cs_n & prev_q.cs_n;
	end

	// idle pin levels: select deasserted, clock low
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_q <= 3'b010;
			sync_q <= 3'b010;
			prev_q <= 3'b010;
			edg_q <= 4'h0;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
			prev_q <= prev_d;
			edg_q <= edg_d;
		end
	end

	assign pins_sync = prev_q;
	assign edges = edg_q;

endmodule

`default_nettype wire
